/* File: verilog/adc_pkg.sv */
// ==================================================
// serial sequencer constants
package adc_pkg;
    localparam int TMR_W   = 20;
    localparam int CNT_W   = 6;
    localparam int RES_W   = 31;
    localparam int XFER_BITS = 32;
    localparam int CHAN_BITS = 8;
    localparam int CFG_END   = 16;

    // ==================================================
    // timing
    localparam int CLK_PERIOD_NS  = 5;
    localparam int POR_TIME_MS    = 4;
    localparam int STATUS_TEST_US = 12;
    localparam int EOSC_TEST_TENTHS = 36;
    localparam logic [TMR_W-1:0] POR_CYCLES_DEF =
        TMR_W'((POR_TIME_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [TMR_W-1:0] STATUS_TEST_CYCLES =
        TMR_W'((STATUS_TEST_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [TMR_W-1:0] EOSC_TEST_TICKS =
        TMR_W'((EOSC_TEST_TENTHS + 9) / 10);
    localparam logic [TMR_W-1:0] INT_OSC_DIV     = 20'h00010;
    localparam logic [TMR_W-1:0] CONV_OSC_CYCLES = 20'h00040;
    localparam logic [TMR_W-1:0] SCK_HALF_CYCLES = 20'h00014;

    // ==================================================
    // pins and reset values
    localparam int PIN_N   = 5;
    localparam int PIN_CS  = 0;
    localparam int PIN_SCK = 1;
    localparam int PIN_SDI = 2;
    localparam int PIN_FO  = 3;
    localparam int PIN_FOX = 4;
    localparam logic [PIN_N-1:0] PIN_RST = 5'h03;
    localparam logic [7:0] CHAN_RST = 8'h00;
    localparam logic [7:0] CFG_RST  = 8'h00;

    typedef enum logic [2:0] {
        ST_POR, ST_CONV, ST_SLEEP, ST_TEST, ST_XFER
    } seq_state_e;

    typedef enum logic [1:0] {
        MODE_EXT, MODE_INT_SC, MODE_INT_CONT
    } clk_mode_e;
endpackage

/* File: verilog/word_if.sv */
`timescale 1ns/1ps
// ==================================================
// word stream with valid and ready
interface word_if #(
    parameter int W = 31
) ();
    logic [W-1:0] data;
    logic         valid;
    logic         ready;

    modport src (output data, output valid, input ready);
    modport snk (input data, input valid, output ready);
endinterface

/* File: verilog/word_buf.sv */
`timescale 1ns/1ps
// ==================================================
// two-entry result buffer
module word_buf
    import adc_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    word_if.snk      in_p,
    word_if.src      out_p
);
    logic [RES_W-1:0] mem [2];
    logic             wr_ff;
    logic             rd_ff;
    logic [1:0]       cnt_ff;
    logic             push;
    logic             pop;

    assign push        = in_p.valid && in_p.ready;
    assign pop         = out_p.valid && out_p.ready;
    assign in_p.ready  = cnt_ff != 2'h2;
    assign out_p.valid = cnt_ff != 2'h0;
    assign out_p.data  = mem[rd_ff];

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ff] <= in_p.data;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wr_ff  <= 1'b0;
            rd_ff  <= 1'b0;
            cnt_ff <= 2'h0;
        end else begin
            wr_ff  <= wr_ff ^ push;
            rd_ff  <= rd_ff ^ pop;
            cnt_ff <= cnt_ff + {1'b0, push} - {1'b0, pop};
        end
    end
endmodule

/* File: verilog/adc_serial.sv */
`timescale 1ns/1ps
// ==================================================
// Contract
// - clock source chosen from sck level when power-on reset ends.
// - external 3-wire: sdo shows end-of-conversion flag continuously.
// - flag falling copies result into the output shift register, except in single-cycle mode with chip select low at conversion end.
// - external clock: sdo changes on sck fall, sdi taken on rise.
// - 32nd external sck fall starts conversion, sdo goes high.
// - pull-up on while sck is high, undriven sck selects internal.
// - internal single-cycle: sdo undriven while chip select high.
// - chip select fall: drive sck low, show flag on sdo.
// - finished: first internal sck rise after status test delay.
// - chip select still low: generate sck, shift data out and in.
// - after 32nd internal rise: convert, hold sck high, repeat.
// - chip select rise during transfer aborts and starts conversion.
// - abort before 8th fall keeps old channel, drops input.
// - abort 8th-16th fall loads channel only; later loads both.
// - pull-up on during reset; high sck with chip select low selects continuous mode.
// - continuous: sck and sdo high converting, low when done.
// - continuous: sleep at least half sck period, then transfer.
// - continuous: sdi on rises, sdo on falls, 32nd rise converts.
// - chip select falling with sck high switches to internal clock.
// - internal sck pull-up off whenever sck is low after power-on reset.
module adc_serial
    import adc_pkg::*;
#(
    parameter logic [TMR_W-1:0] POR_CYCLES = POR_CYCLES_DEF
) (
    input  wire logic             clk,
    input  wire logic             rst_b,
    input  wire logic             cs_b,
    input  wire logic             sck_i,
    input  wire logic             sdi,
    input  wire logic             fo_i,
    input  wire logic             fo_ext,
    input  wire logic [RES_W-1:0] result_word,
    output logic                  sck_o,
    output logic                  sck_oe,
    output logic                  sck_pu,
    output logic                  sdo_o,
    output logic                  sdo_oe,
    output logic [7:0]            chan_o,
    output logic [7:0]            cfg_o
);
    // ==================================================
    // pin synchronisers
    logic [PIN_N-1:0] pin_raw;
    logic [PIN_N-1:0] pin_s;
    logic [PIN_N-1:0] pin_d_ff;
    logic [PIN_N-1:0] rise_v;
    logic [PIN_N-1:0] fall_v;

    assign pin_raw = {fo_ext, fo_i, sdi, sck_i, cs_b};

    genvar gi;
    generate
        for (gi = 0; gi < PIN_N; gi++) begin : g_sync
            logic s1_ff;
            logic s2_ff;
            always_ff @(posedge clk or negedge rst_b) begin
                if (!rst_b) begin
                    s1_ff <= PIN_RST[gi];
                    s2_ff <= PIN_RST[gi];
                end else begin
                    s1_ff <= pin_raw[gi];
                    s2_ff <= s1_ff;
                end
            end
            assign pin_s[gi] = s2_ff;
        end
    endgenerate

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pin_d_ff <= PIN_RST;
        end else begin
            pin_d_ff <= pin_s;
        end
    end

    assign rise_v = pin_s & ~pin_d_ff;
    assign fall_v = ~pin_s & pin_d_ff;

    logic cs_s;
    logic sck_s;
    logic sdi_s;
    logic fo_ext_s;
    logic cs_rise;
    logic cs_fall;
    logic sck_rise;
    logic sck_fall;

    assign cs_s     = pin_s[PIN_CS];
    assign sck_s    = pin_s[PIN_SCK];
    assign sdi_s    = pin_s[PIN_SDI];
    assign fo_ext_s = pin_s[PIN_FOX];
    assign cs_rise  = rise_v[PIN_CS];
    assign cs_fall  = fall_v[PIN_CS];
    assign sck_rise = rise_v[PIN_SCK];
    assign sck_fall = fall_v[PIN_SCK];

    function automatic logic drives_sck(clk_mode_e m, logic cs);
        drives_sck = (m == MODE_INT_CONT) || (m == MODE_INT_SC && !cs);
    endfunction

    // ==================================================
    // state
    seq_state_e       state_ff;
    seq_state_e       nxt_state;
    clk_mode_e        mode_ff;
    clk_mode_e        nxt_mode;
    logic [TMR_W-1:0] timer_ff;
    logic [TMR_W-1:0] nxt_timer;
    logic [TMR_W-1:0] div_ff;
    logic [CNT_W-1:0] rise_cnt_ff;
    logic [CNT_W-1:0] nxt_rise;
    logic [CNT_W-1:0] fall_cnt_ff;
    logic [CNT_W-1:0] nxt_fall;
    logic [RES_W:0]   shout_ff;
    logic [RES_W:0]   nxt_shout;
    logic [7:0]       chsh_ff;
    logic [7:0]       nxt_chsh;
    logic [7:0]       cfsh_ff;
    logic [7:0]       nxt_cfsh;
    logic [7:0]       chan_ff;
    logic [7:0]       nxt_chan;
    logic [7:0]       cfg_ff;
    logic [7:0]       nxt_cfg;
    logic             loaded_ff;
    logic             nxt_loaded;
    logic             sck_o_ff;
    logic             nxt_sck;
    logic             sck_oe_ff;
    logic             sck_pu_ff;
    logic             sdo_ff;
    logic             sdo_oe_ff;
    logic             rise_ev;
    logic             fall_ev;

    // ==================================================
    // oscillator tick and result buffer
    logic             div_tick;
    logic             osc_tick;
    logic             conv_done;
    logic             test_tick;
    logic [TMR_W-1:0] test_last;

    assign div_tick  = div_ff == INT_OSC_DIV - 1'b1;
    assign osc_tick  = fo_ext_s ? rise_v[PIN_FO] : div_tick;
    assign conv_done = state_ff == ST_CONV && timer_ff == CONV_OSC_CYCLES;
    assign test_tick = fo_ext_s ? osc_tick : 1'b1;
    assign test_last = fo_ext_s ? EOSC_TEST_TICKS - 1'b1
                                : STATUS_TEST_CYCLES - 1'b1;

    word_if #(.W(RES_W)) push_if ();
    word_if #(.W(RES_W)) pop_if ();

    assign push_if.valid = conv_done;
    assign push_if.data  = result_word;
    assign pop_if.ready  = state_ff == ST_SLEEP && !loaded_ff;

    word_buf u_buf (
        .clk   (clk),
        .rst_b (rst_b),
        .in_p  (push_if),
        .out_p (pop_if)
    );

    // ==================================================
    // sequencer
    always_comb begin
        nxt_state  = state_ff;
        nxt_mode   = mode_ff;
        nxt_timer  = timer_ff;
        nxt_sck    = sck_o_ff;
        nxt_loaded = loaded_ff;
        nxt_shout  = shout_ff;
        nxt_chsh   = chsh_ff;
        nxt_cfsh   = cfsh_ff;
        nxt_chan   = chan_ff;
        nxt_cfg    = cfg_ff;
        nxt_rise   = rise_cnt_ff;
        nxt_fall   = fall_cnt_ff;
        rise_ev    = 1'b0;
        fall_ev    = 1'b0;
        if (cs_fall && state_ff != ST_POR && mode_ff != MODE_INT_CONT) begin
            nxt_mode = sck_s ? MODE_INT_SC : MODE_EXT;
        end
        if (cs_rise) begin
            nxt_sck = 1'b1;
        end
        unique case (state_ff)
            ST_POR: begin
                nxt_timer = timer_ff + 1'b1;
                if (timer_ff == POR_CYCLES) begin
                    // sck low: external; chip select low: continuous
                    if (!sck_s) begin
                        nxt_mode = MODE_EXT;
                    end else if (cs_s) begin
                        nxt_mode = MODE_INT_SC;
                    end else begin
                        nxt_mode = MODE_INT_CONT;
                    end
                    nxt_state = ST_CONV;
                    nxt_timer = '0;
                    nxt_sck   = 1'b1;
                end
            end
            ST_CONV: begin
                if (nxt_mode == MODE_INT_SC && cs_fall) begin
                    nxt_sck = 1'b0;
                end
                if (osc_tick && !conv_done) begin
                    nxt_timer = timer_ff + 1'b1;
                end
                if (conv_done && push_if.ready) begin
                    nxt_timer  = '0;
                    nxt_loaded = 1'b0;
                    if (mode_ff == MODE_INT_SC && !cs_s) begin
                        nxt_state = ST_TEST;
                        nxt_sck   = 1'b0;
                    end else begin
                        nxt_state = ST_SLEEP;
                        if (mode_ff == MODE_INT_CONT) begin
                            nxt_sck = 1'b0;
                        end
                    end
                end
            end
            ST_SLEEP: begin
                if (!loaded_ff) begin
                    if (pop_if.valid) begin
                        nxt_shout  = {1'b0, pop_if.data};
                        nxt_loaded = 1'b1;
                    end
                end else if (nxt_mode == MODE_EXT) begin
                    if (!cs_s && sck_rise) begin
                        nxt_state = ST_XFER;
                        rise_ev   = 1'b1;
                    end
                end else if (nxt_mode == MODE_INT_SC) begin
                    if (!cs_s) begin
                        nxt_state = ST_TEST;
                        nxt_sck   = 1'b0;
                        nxt_timer = '0;
                    end
                end else begin
                    nxt_timer = timer_ff + 1'b1;
                    if (timer_ff == SCK_HALF_CYCLES - 1'b1) begin
                        nxt_state = ST_XFER;
                        nxt_sck   = 1'b1;
                        nxt_timer = '0;
                        rise_ev   = 1'b1;
                    end
                end
            end
            ST_TEST: begin
                if (cs_s) begin
                    nxt_state = ST_SLEEP;
                    nxt_timer = '0;
                end else if (test_tick) begin
                    nxt_timer = timer_ff + 1'b1;
                    if (timer_ff == test_last) begin
                        nxt_state = ST_XFER;
                        nxt_sck   = 1'b1;
                        nxt_timer = '0;
                        rise_ev   = 1'b1;
                    end
                end
            end
            ST_XFER: begin
                // chip select is held low in continuous mode
                if (cs_rise && mode_ff != MODE_INT_CONT) begin
                    nxt_state = ST_CONV;
                    nxt_timer = '0;
                    if (fall_cnt_ff >= CNT_W'(CFG_END)) begin
                        nxt_chan = chsh_ff;
                        nxt_cfg  = cfsh_ff;
                    end else if (fall_cnt_ff >= CNT_W'(CHAN_BITS)) begin
                        nxt_chan = chsh_ff;
                    end
                end else if (mode_ff == MODE_EXT) begin
                    if (sck_rise) begin
                        rise_ev = 1'b1;
                    end
                    if (sck_fall) begin
                        if (fall_cnt_ff == CNT_W'(XFER_BITS - 1)) begin
                            nxt_state = ST_CONV;
                            nxt_timer = '0;
                            nxt_chan  = chsh_ff;
                            nxt_cfg   = cfsh_ff;
                        end else begin
                            fall_ev = 1'b1;
                        end
                    end
                end else begin
                    nxt_timer = timer_ff + 1'b1;
                    if (timer_ff == SCK_HALF_CYCLES - 1'b1) begin
                        nxt_timer = '0;
                        nxt_sck   = !sck_o_ff;
                        if (sck_o_ff) begin
                            fall_ev = 1'b1;
                        end else begin
                            rise_ev = 1'b1;
                            if (rise_cnt_ff == CNT_W'(XFER_BITS - 1)) begin
                                nxt_state = ST_CONV;
                                nxt_chan  = chsh_ff;
                                nxt_cfg   = cfsh_ff;
                            end
                        end
                    end
                end
            end
        endcase
        if (rise_ev) begin
            nxt_rise = rise_cnt_ff + 1'b1;
            if (rise_cnt_ff < CNT_W'(CHAN_BITS)) begin
                nxt_chsh = {chsh_ff[6:0], sdi_s};
            end else if (rise_cnt_ff < CNT_W'(CFG_END)) begin
                nxt_cfsh = {cfsh_ff[6:0], sdi_s};
            end
        end
        if (fall_ev) begin
            nxt_fall  = fall_cnt_ff + 1'b1;
            nxt_shout = {shout_ff[RES_W-1:0], 1'b0};
        end
        if (nxt_state == ST_CONV && state_ff != ST_CONV) begin
            nxt_rise = '0;
            nxt_fall = '0;
        end
    end

    // ==================================================
    // pin drive
    logic nxt_sck_oe;
    logic nxt_sdo;
    logic nxt_sdo_oe;
    logic nxt_pu;

    assign nxt_sck_oe = nxt_state != ST_POR && drives_sck(nxt_mode, cs_s);
    assign nxt_sdo    = nxt_state == ST_XFER ? nxt_shout[RES_W]
                      : (nxt_state == ST_CONV || nxt_state == ST_POR);
    assign nxt_sdo_oe = nxt_state != ST_POR && !cs_s;
    assign nxt_pu     = nxt_state == ST_POR || sck_s;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_ff    <= ST_POR;
            mode_ff     <= MODE_INT_SC;
            timer_ff    <= '0;
            div_ff      <= '0;
            rise_cnt_ff <= '0;
            fall_cnt_ff <= '0;
            shout_ff    <= '0;
            chsh_ff     <= CHAN_RST;
            cfsh_ff     <= CFG_RST;
            chan_ff     <= CHAN_RST;
            cfg_ff      <= CFG_RST;
            loaded_ff   <= 1'b0;
            sck_o_ff    <= 1'b1;
            sck_oe_ff   <= 1'b0;
            sck_pu_ff   <= 1'b1;
            sdo_ff      <= 1'b1;
            sdo_oe_ff   <= 1'b0;
        end else begin
            state_ff    <= nxt_state;
            mode_ff     <= nxt_mode;
            timer_ff    <= nxt_timer;
            div_ff      <= div_tick ? '0 : div_ff + 1'b1;
            rise_cnt_ff <= nxt_rise;
            fall_cnt_ff <= nxt_fall;
            shout_ff    <= nxt_shout;
            chsh_ff     <= nxt_chsh;
            cfsh_ff     <= nxt_cfsh;
            chan_ff     <= nxt_chan;
            cfg_ff      <= nxt_cfg;
            loaded_ff   <= nxt_loaded;
            sck_o_ff    <= nxt_sck;
            sck_oe_ff   <= nxt_sck_oe;
            sck_pu_ff   <= nxt_pu;
            sdo_ff      <= nxt_sdo;
            sdo_oe_ff   <= nxt_sdo_oe;
        end
    end

    assign sck_o  = sck_o_ff;
    assign sck_oe = sck_oe_ff;
    assign sck_pu = sck_pu_ff;
    assign sdo_o  = sdo_ff;
    assign sdo_oe = sdo_oe_ff;
    assign chan_o = chan_ff;
    assign cfg_o  = cfg_ff;

    // ==================================================
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    sequence s_test_go;
        (state_ff == ST_TEST && !fo_ext_s) ##1 (state_ff == ST_XFER);
    endsequence

    sequence s_cont_go;
        (state_ff == ST_SLEEP && mode_ff == MODE_INT_CONT) ##1 (state_ff == ST_XFER);
    endsequence

    sequence s_abort;
        state_ff == ST_XFER && cs_rise && mode_ff != MODE_INT_CONT;
    endsequence

    AST_POR_SEL: assert property (
        state_ff == ST_POR && timer_ff == POR_CYCLES
        |=> state_ff == ST_CONV && (mode_ff == MODE_EXT) == !$past(sck_s))
        else $error("clock source not taken from sck at reset end");
    AST_SDO_CONV: assert property (
        state_ff == ST_CONV |-> sdo_ff)
        else $error("sdo not high while converting");
    AST_SDO_HIZ: assert property (
        cs_s |=> !sdo_oe_ff)
        else $error("sdo driven with chip select high");
    AST_EXT_SCK: assert property (
        mode_ff == MODE_EXT |-> !sck_oe_ff)
        else $error("sck driven in external clock mode");
    AST_EXT_END: assert property (
        state_ff == ST_XFER && mode_ff == MODE_EXT && sck_fall && !cs_rise
        && fall_cnt_ff == 6'd31 |=> state_ff == ST_CONV && sdo_ff)
        else $error("32nd external fall did not start conversion");
    AST_INT_END: assert property (
        state_ff == ST_XFER && mode_ff != MODE_EXT && !cs_rise && !sck_o_ff
        && rise_cnt_ff == 6'd31 && timer_ff == SCK_HALF_CYCLES - 1'b1
        |=> (state_ff == ST_CONV && sck_o_ff)[*2])
        else $error("sck not held high after 32nd internal rise");
    AST_ABORT: assert property (
        s_abort |=> state_ff == ST_CONV && rise_cnt_ff == 6'd0)
        else $error("abort did not start conversion");
    AST_CHAN_KEEP: assert property (
        s_abort and (fall_cnt_ff < CNT_W'(CHAN_BITS))
        |=> $stable(chan_ff) && $stable(cfg_ff))
        else $error("early abort changed channel");
    AST_CFG_KEEP: assert property (
        s_abort and (fall_cnt_ff >= CNT_W'(CHAN_BITS) && fall_cnt_ff < CNT_W'(CFG_END))
        |=> chan_ff == $past(chsh_ff) && $stable(cfg_ff))
        else $error("mid abort loaded wrong fields");
    AST_TEST_DLY: assert property (
        s_test_go |-> $past(timer_ff) == STATUS_TEST_CYCLES - 1'b1 && sck_o_ff)
        else $error("first sck rise not at status test delay");
    AST_TEST_SCK: assert property (
        state_ff == ST_TEST |-> sck_oe_ff && !sck_o_ff && !sdo_ff)
        else $error("status test without sck low and flag low");
    AST_CONT_SLEEP: assert property (
        state_ff == ST_SLEEP && mode_ff == MODE_INT_CONT |-> !sck_o_ff && !sdo_ff)
        else $error("continuous sleep without sck and sdo low");
    AST_CONT_MIN: assert property (
        s_cont_go |-> $past(timer_ff) == SCK_HALF_CYCLES - 1'b1)
        else $error("continuous sleep shorter than half sck period");
    AST_PU_OFF: assert property (
        !sck_s && state_ff != ST_POR |=> !sck_pu_ff)
        else $error("pull-up on while sck low");
    AST_PU_POR: assert property (
        state_ff == ST_POR |-> sck_pu_ff)
        else $error("pull-up off during reset");
endmodule

/* File: tb/host_model.sv */
`timescale 1ns/1ps
// ==================================================
// serial host with board pull-up on sck and sdo
module host_model (
    input  wire logic sck_o,
    input  wire logic sck_oe,
    input  wire logic sdo_o,
    input  wire logic sdo_oe,
    output logic      sck_w,
    output logic      sdi,
    output logic      sdo_w
);
    logic drv_en;
    logic drv_sck;
    initial begin
        drv_en = 1'b1;
        drv_sck = 1'b0;
        sdi = 1'b0;
    end
    // released sck or sdo floats up to the board resistor
    assign sck_w = sck_oe ? sck_o : (drv_en ? drv_sck : 1'b1);
    assign sdo_w = sdo_oe ? sdo_o : 1'b1;

    // 80 ns sck; sdi moves at fall, sdo taken at rise
    task automatic xfer(input logic [31:0] din, output logic [31:0] dout);
        #1;
        for (int i = 31; i >= 0; i--) begin
            sdi = din[i];
            #40 drv_sck = 1'b1;
            dout[i] = sdo_w;
            #40 drv_sck = 1'b0;
        end
    endtask
endmodule

/* File: tb/adc_serial_timing_modes_test.sv */
`timescale 1ns/1ps
module adc_serial_timing_modes_test;
    import adc_pkg::*;
    logic             clk = 1'b0;
    logic             rst_b = 1'b0;
    logic             cs_b = 1'b0;
    logic             fo_i = 1'b0;
    logic             fo_ext = 1'b0;
    logic [RES_W-1:0] res = 31'h2a5c3e1f;
    logic             sck_o, sck_oe, sck_pu, sdo_o, sdo_oe, sck_w, sdi, sdo_w;
    logic [7:0]       chan, cfg;
    logic [31:0]      d;
    int               n_fail = 0;
    int               tests_run = 0;

    always #2.5 clk = ~clk;

    adc_serial #(.POR_CYCLES(20'h00032)) dut_u (.clk(clk), .rst_b(rst_b), .cs_b(cs_b),
        .sck_i(sck_w), .sdi(sdi), .fo_i(fo_i), .fo_ext(fo_ext), .result_word(res),
        .sck_o(sck_o), .sck_oe(sck_oe), .sck_pu(sck_pu), .sdo_o(sdo_o), .sdo_oe(sdo_oe),
        .chan_o(chan), .cfg_o(cfg));
    host_model host_u (.sck_o(sck_o), .sck_oe(sck_oe), .sdo_o(sdo_o), .sdo_oe(sdo_oe),
        .sck_w(sck_w), .sdi(sdi), .sdo_w(sdo_w));

    // ==================================================
    // shared tasks
    task stop_test;
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    task check(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    // sel 1 watches sck wire, sel 0 watches sdo wire
    task automatic wait_lvl(input bit sel, input logic v, input int lim);
        for (int i = 0; i < lim; i++) begin
            if ((sel ? sck_w : sdo_w) === v) return;
            @(posedge clk);
        end
        n_fail++;
        $display("MISMATCH wait sel %0d expected %b timed out", sel, v);
        stop_test();
    endtask

    task do_reset(input logic ext);
        #1 rst_b = 1'b0;
        host_u.drv_en = ext;
        repeat (20) @(posedge clk);
        #1 rst_b = 1'b1;
    endtask

    // ==================================================
    // external clock, chip select tied low
    task ext_3wire;
        do_reset(1'b1);
        wait_lvl(0, 1'b0, 5000);
        check("chan_rst", 32'(CHAN_RST), 32'(chan));
        check("ext_pu_off", 32'h0, 32'(sck_pu));
        host_u.xfer({8'ha5, 8'h3c, 16'hffff}, d);
        check("ext_word", {1'b0, res}, d);
        repeat (8) @(posedge clk);
        check("ext_flag_hi", 32'h1, 32'(sdo_w));
        check("ext_chan", 32'ha5, 32'(chan));
        check("ext_cfg", 32'h3c, 32'(cfg));
        wait_lvl(0, 1'b0, 5000);
        repeat (30) @(posedge clk);
        check("ext_flag_lo", 32'h0, 32'(sdo_w));
    endtask

    // ==================================================
    // internal clock, continuous conversion
    task int_cont;
        logic [31:0] din;
        din = {8'h5a, 8'hc3, 16'h0f0f};
        do_reset(1'b0);
        wait_lvl(1, 1'b0, 5000);
        check("cont_sdo_lo", 32'h0, 32'(sdo_w));
        for (int i = 31; i >= 0; i--) begin
            #1 host_u.sdi = din[i];
            wait_lvl(1, 1'b1, 100);
            d[i] = sdo_w;
            if (i > 0) wait_lvl(1, 1'b0, 100);
        end
        check("cont_word", {1'b0, res}, d);
        repeat (30) @(posedge clk);
        check("cont_sck_hi", 32'h1, 32'(sck_w));
        check("cont_sdo_hi", 32'h1, 32'(sdo_w));
        check("cont_chan", 32'h5a, 32'(chan));
        check("cont_cfg", 32'hc3, 32'(cfg));
    endtask

    // ==================================================
    // internal clock, single cycle: status test, n bits, then abort
    task automatic int_burst(input logic [11:0] din, input int n);
        #1 cs_b = 1'b0;
        wait_lvl(1, 1'b0, 10);
        repeat (2380) @(posedge clk);
        check("test_sck_lo", 32'h0, 32'(sck_w));
        for (int i = n - 1; i >= 0; i--) begin
            #1 host_u.sdi = din[i];
            wait_lvl(1, 1'b1, 100);
            d[i] = sdo_w;
            wait_lvl(1, 1'b0, 100);
        end
        #1 cs_b = 1'b1;
        repeat (10) @(posedge clk);
    endtask

    task int_single;
        do_reset(1'b0);
        cs_b = 1'b1;
        repeat (1200) @(posedge clk);
        #1 cs_b = 1'b0;
        wait_lvl(1, 1'b0, 10);
        check("test_flag", 32'h0, 32'(sdo_w));
        repeat (20) @(posedge clk);
        #1 cs_b = 1'b1;
        repeat (10) @(posedge clk);
        check("test_sleep_sck", 32'h1, 32'(sck_w));
        check("test_pu", 32'h1, 32'(sck_pu));
        check("test_sdo_hiz", 32'h1, 32'(sdo_w));
        int_burst({8'h96, 4'h5}, 12);
        check("abort_word", {20'h0, 1'b0, res[30:20]}, {20'h0, d[11:0]});
        check("abort_chan", 32'h96, 32'(chan));
        check("abort_cfg", 32'(CFG_RST), 32'(cfg));
        repeat (1100) @(posedge clk);
        int_burst(12'h003, 4);
        check("early_word", {28'h0, 1'b0, res[30:28]}, {28'h0, d[3:0]});
        check("early_chan", 32'h96, 32'(chan));
        check("early_cfg", 32'(CFG_RST), 32'(cfg));
    endtask

    initial begin
        ext_3wire();
        int_cont();
        int_single();
        stop_test();
    end
endmodule
